// file: rtl/jsli_map.vh
`ifndef JSLI_MAP_VH
`define JSLI_MAP_VH
// ****************************************
// sync source select codes
// ****************************************
`define JSLI_SRC_SINGLE 2'h0
`define JSLI_SRC_DIFF 2'h1
`define JSLI_SRC_TSTAMP 2'h2
// ****************************************
// encoding modes
// ****************************************
`define JSLI_ENC_8B10B 1'b0
`define JSLI_ENC_64B66B 1'b1
// ****************************************
// init states
// ****************************************
`define JSLI_ST_IDLE 2'h0
`define JSLI_ST_CGS 2'h1
`define JSLI_ST_ILAS 2'h2
`define JSLI_ST_DATA 2'h3
// ****************************************
// timing
// ****************************************
`define JSLI_SYNC_STAGES 2
`define JSLI_ILAS_MULTIFRAMES 4
`endif

// file: rtl/jsli_sync.v
`default_nettype none
// ****************************************
// two or more flop level synchroniser
// ****************************************
module jsli_sync #(
    parameter STAGES = 2,
    parameter RESET_VAL = 1'b1
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire async_i,
    output wire sync_o
);
    reg [STAGES-1:0] chain_q;
    // first stage feeds only the next stage
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            chain_q <= {STAGES{RESET_VAL}};
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_i};
        end
    end
    assign sync_o = chain_q[STAGES-1];
endmodule
`default_nettype wire

// file: rtl/jsli_link_init.v
// Summary of operation
// - single-ended sync used only when select 0, 8B/10B
// - sync request is active low
// - low request starts code group sync
// - rising request starts lane alignment sequence
// - 64B/66B modes ignore sync request
// - other sources disregard single-ended sync
// - sysref receiver off when enable cleared
// - timestamp input may serve as sync, 8B/10B
`include "jsli_map.vh"
`default_nettype none
module jsli_link_init #(
    parameter STAGES = `JSLI_SYNC_STAGES,
    parameter ILAS_MF = `JSLI_ILAS_MULTIFRAMES
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire single_ended_sync_in_n_i,
    input wire differential_sync_in_n_i,
    input wire timestamp_in_n_i,
    input wire sysref_in_i,
    input wire [1:0] sync_source_select_i,
    input wire encoding_mode_i,
    input wire sysref_receiver_enable_i,
    input wire multiframe_end_i,
    output reg send_cgs_o,
    output reg send_ilas_o,
    output reg send_data_o,
    output reg [1:0] init_state_o,
    output reg sysref_receiver_power_o,
    output reg sysref_pulse_o
);
    // ****************************************
    // synchronisers
    // ****************************************
    wire se_s;
    wire diff_s;
    wire ts_s;
    wire sr_s;
    // every sync and sysref pin passes the chain before any logic
    jsli_sync #(.STAGES(STAGES), .RESET_VAL(1'b1)) u_se (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(single_ended_sync_in_n_i),
        .sync_o(se_s)
    );
    jsli_sync #(.STAGES(STAGES), .RESET_VAL(1'b1)) u_diff (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(differential_sync_in_n_i),
        .sync_o(diff_s)
    );
    jsli_sync #(.STAGES(STAGES), .RESET_VAL(1'b1)) u_ts (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(timestamp_in_n_i),
        .sync_o(ts_s)
    );
    // ungated input: the enable is applied only after the chain
    jsli_sync #(.STAGES(STAGES), .RESET_VAL(1'b0)) u_sr (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(sysref_in_i),
        .sync_o(sr_s)
    );
    // ****************************************
    // source selection
    // ****************************************
    function sel_sync;
        input [1:0] sel;
        input a;
        input b;
        input c;
        begin
            case (sel)
                `JSLI_SRC_SINGLE: sel_sync = a;
                `JSLI_SRC_DIFF: sel_sync = b;
                `JSLI_SRC_TSTAMP: sel_sync = c;
                default: sel_sync = 1'b1;
            endcase
        end
    endfunction
    // ****************************************
    // request selection
    // ****************************************
    wire is_8b10b = (encoding_mode_i == `JSLI_ENC_8B10B);
    // 64b66b forces an idle level: no request ever seen
    wire req_n = is_8b10b ?
        sel_sync(sync_source_select_i, se_s, diff_s, ts_s) : 1'b1;
    reg req_n_q;
    wire req_fall = req_n_q & ~req_n;
    wire req_rise = ~req_n_q & req_n;
    reg sr_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] mf_cnt_q;
    reg [7:0] mf_cnt_d;
    // counter kept 8 bits: alignment length stays below 256
    wire ilas_last = (mf_cnt_q == ILAS_MF[7:0] - 8'h01);
    // ****************************************
    // state decode
    // ****************************************
    function in_state;
        input [1:0] st;
        input [1:0] want;
        begin
            in_state = (st == want);
        end
    endfunction
    // ****************************************
    // init state machine
    // ****************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            `JSLI_ST_IDLE: begin
                // level, not edge: a request held over reset counts
                if (!is_8b10b) begin
                    state_d = `JSLI_ST_DATA;
                end else if (!req_n) begin
                    state_d = `JSLI_ST_CGS;
                end
            end
            `JSLI_ST_CGS: begin
                // only the rising edge, or 64b66b mode, leaves cgs
                if (!is_8b10b) begin
                    state_d = `JSLI_ST_DATA;
                end else if (req_rise) begin
                    state_d = `JSLI_ST_ILAS;
                end
            end
            `JSLI_ST_ILAS: begin
                if (!is_8b10b) begin
                    state_d = `JSLI_ST_DATA;
                end else if (!req_n) begin
                    state_d = `JSLI_ST_CGS;
                end else if (multiframe_end_i && ilas_last) begin
                    state_d = `JSLI_ST_DATA;
                end
            end
            `JSLI_ST_DATA: begin
                // a new low request restarts the link
                if (is_8b10b && req_fall) begin
                    state_d = `JSLI_ST_CGS;
                end
            end
            default: state_d = `JSLI_ST_IDLE;
        endcase
    end
    // ****************************************
    // alignment length counter
    // ****************************************
    // cleared outside ilas so a restart always counts from zero
    always @* begin
        mf_cnt_d = mf_cnt_q;
        if (!in_state(state_q, `JSLI_ST_ILAS)) begin
            mf_cnt_d = 8'h00;
        end else if (is_8b10b && req_n && multiframe_end_i) begin
            mf_cnt_d = mf_cnt_q + 8'h01;
        end
    end
    // ****************************************
    // request edge detect
    // ****************************************
    // resets to the idle level so no false edge follows reset
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            req_n_q <= 1'b1;
        end else begin
            req_n_q <= req_n;
        end
    end
    // ****************************************
    // state registers
    // ****************************************
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= `JSLI_ST_IDLE;
            mf_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            mf_cnt_q <= mf_cnt_d;
        end
    end
    // ****************************************
    // lane outputs
    // ****************************************
    // taken from the next state so outputs line up with state_q
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            send_cgs_o <= 1'b0;
            send_ilas_o <= 1'b0;
            send_data_o <= 1'b0;
            init_state_o <= `JSLI_ST_IDLE;
        end else begin
            send_cgs_o <= in_state(state_d, `JSLI_ST_CGS);
            send_ilas_o <= in_state(state_d, `JSLI_ST_ILAS);
            send_data_o <= in_state(state_d, `JSLI_ST_DATA);
            init_state_o <= state_d;
        end
    end
    // ****************************************
    // system reference receiver
    // ****************************************
    // enable gates after the chain so the pin only meets flops
    // limitation: a pin already high at enable gives no pulse
    always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sr_q <= 1'b0;
            sysref_receiver_power_o <= 1'b0;
            sysref_pulse_o <= 1'b0;
        end else begin
            sr_q <= sr_s;
            sysref_receiver_power_o <= sysref_receiver_enable_i;
            sysref_pulse_o <= sysref_receiver_enable_i & sr_s & ~sr_q;
        end
    end
endmodule
`default_nettype wire

// file: tb/jsli_rx_model.sv
`default_nettype none
// ****
// link receiver: owns the active-low request
// ****
module jsli_rx_model (
    input wire logic clk_sys_i,
    input wire logic want_sync_i,
    output var logic sync_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // low asks for cgs, high once want_sync_i drops
    always @(posedge clk_sys_i) sync_n_o <= !want_sync_i;
endmodule
`default_nettype wire

// file: tb/jsli_checker.sv
`default_nettype none
module jsli_checker (
    input wire logic clk_sys_i, sys_rst_i, single_ended_sync_in_n_i,
    input wire logic timestamp_in_n_i, differential_sync_in_n_i,
    input wire logic [1:0] sync_source_select_i,
    input wire logic encoding_mode_i, sysref_receiver_enable_i,
    input wire logic send_cgs_o, send_ilas_o, sysref_pulse_o,
    input wire logic sysref_receiver_power_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire sn = single_ended_sync_in_n_i;
    wire wide = encoding_mode_i;
    wire [1:0] sel = sync_source_select_i;
    wire se8 = sel == 2'h0 && !wide;
    // four samples: covers either reading of the sync latency
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_low_cgs: assert property (
        (se8 && !sn)[*4] |=> send_cgs_o) else $error("no cgs");
    a_rise_ilas: assert property (
        se8 && send_cgs_o && $rose(sn) ##1 (se8 && sn)[*3] |=> send_ilas_o)
        else $error("no ilas");
    a_no_early: assert property (
        se8 && !send_cgs_o && $fell(sn) |=> !send_cgs_o) else $error("early");
    a_wide_quiet: assert property (
        wide[*4] |-> !send_cgs_o && !send_ilas_o) else $error("wide sync");
    a_ts_cgs: assert property (
        (sel == 2'h2 && !wide && !timestamp_in_n_i)[*4] |=> send_cgs_o)
        else $error("ts no cgs");
    a_other_src: assert property (
        (sel != 2'h0 && timestamp_in_n_i && differential_sync_in_n_i)[*4]
        |-> !send_cgs_o) else $error("se used");
    a_rx_off: assert property (
        (!sysref_receiver_enable_i)[*2] |-> !sysref_receiver_power_o
        && !sysref_pulse_o) else $error("rx on");
    a_pulse_one: assert property (
        sysref_pulse_o |=> !sysref_pulse_o) else $error("long pulse");
    cover property (send_ilas_o);
    cover property (sysref_pulse_o);
    cover property (se8 && send_cgs_o);
endmodule
bind jsli_link_init jsli_checker chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, sys_rst_i = 1, want = 0, multiframe_end_i = 0;
    logic differential_sync_in_n_i = 1, timestamp_in_n_i = 1;
    logic sysref_in_i = 0, sysref_receiver_enable_i = 0;
    logic encoding_mode_i = 0;
    logic [1:0] sync_source_select_i = 2'h0, init_state_o, n;
    logic single_ended_sync_in_n_i, send_cgs_o, send_ilas_o, send_data_o;
    logic sysref_receiver_power_o, sysref_pulse_o;
    int n_errors = 0, tests_run = 0;
    initial forever #2 clk_sys_i = ~clk_sys_i;
    jsli_rx_model rx (.clk_sys_i(clk_sys_i), .want_sync_i(want),
        .sync_n_o(single_ended_sync_in_n_i));
    jsli_link_init uut (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .single_ended_sync_in_n_i(single_ended_sync_in_n_i),
        .differential_sync_in_n_i(differential_sync_in_n_i),
        .timestamp_in_n_i(timestamp_in_n_i),
        .sysref_in_i(sysref_in_i),
        .sync_source_select_i(sync_source_select_i),
        .encoding_mode_i(encoding_mode_i),
        .sysref_receiver_enable_i(sysref_receiver_enable_i),
        .multiframe_end_i(multiframe_end_i),
        .send_cgs_o(send_cgs_o),
        .send_ilas_o(send_ilas_o),
        .send_data_o(send_data_o),
        .init_state_o(init_state_o),
        .sysref_receiver_power_o(sysref_receiver_power_o),
        .sysref_pulse_o(sysref_pulse_o)
    );
    task automatic chk(input string nm, input logic [1:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    // sync reset, 6 cycles; config is static so set it here
    task automatic restart(input logic [1:0] s, input logic w);
        sys_rst_i = 1;
        sync_source_select_i = s;
        encoding_mode_i = w;
        want = 0;
        tick(6);
        chk("rst", init_state_o, 2'h0);
        sys_rst_i = 0;
    endtask
    task automatic t_link;
        restart(2'h0, 0);
        want = 1;
        tick(3);
        chk("early", send_cgs_o, 0);
        tick(3);
        chk("cgs", init_state_o, 2'h1);
        want = 0;
        tick(7);
        chk("ilas", send_ilas_o, 1);
        repeat (4) begin
            multiframe_end_i = 1;
            tick(1);
            multiframe_end_i = 0;
            tick(1);
        end
        tick(2);
        chk("data", send_data_o, 1);
        want = 1;
        tick(7);
        chk("recgs", send_cgs_o, 1);
        $display("link done");
    endtask
    task automatic t_src;
        restart(2'h2, 0);
        want = 1;
        tick(7);
        chk("se off", send_cgs_o, 0);
        timestamp_in_n_i = 0;
        tick(7);
        chk("ts", send_cgs_o, 1);
        timestamp_in_n_i = 1;
        restart(2'h1, 0);
        differential_sync_in_n_i = 0;
        tick(7);
        chk("diff", send_cgs_o, 1);
        differential_sync_in_n_i = 1;
        restart(2'h0, 1);
        want = 1;
        tick(7);
        chk("wide", send_cgs_o | send_ilas_o, 0);
        chk("wide data", send_data_o, 1);
        restart(2'h3, 0);
        want = 1;
        timestamp_in_n_i = 0;
        differential_sync_in_n_i = 0;
        tick(7);
        chk("no source", send_cgs_o, 0);
        timestamp_in_n_i = 1;
        differential_sync_in_n_i = 1;
        $display("sources done");
    endtask
    // count pulses over a window since sysref latency is not fixed
    task automatic t_ref(input logic en, input logic [1:0] exp);
        sysref_receiver_enable_i = en;
        sysref_in_i = 0;
        n = 0;
        tick(4);
        chk("pwr", sysref_receiver_power_o, en);
        sysref_in_i = 1;
        repeat (8) begin
            tick(1);
            n = n + sysref_pulse_o;
        end
        chk("pulse", n, exp);
        $display("sysref done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        t_link;
        t_src;
        t_ref(1, 2'h1);
        t_ref(0, 2'h0);
        close_out;
    end
endmodule
`default_nettype wire
